// ==== common/sos_map.svh ====
// Selection codes, register offsets and reset values for the status output selector
`ifndef SOS_MAP_SVH
`define SOS_MAP_SVH
`define SOS_CODE_TIMER 6'h1E
`define SOS_CODE_AIN_WINDOW 6'h1F
`define SOS_CODE_STOPPED 6'h20
`define SOS_CODE_REVERSE 6'h21
`define SOS_CODE_HEATSINK 6'h23
`define SOS_CODE_LOW_FREQ 6'h25
`define SOS_CODE_ALARM_CONT 6'h26
`define SOS_CODE_RUN_TIME 6'h28
`define SOS_OFS_SELECT 4'h0
`define SOS_OFS_TIMER_CTRL 4'h1
`define SOS_OFS_TIMER_DUR 4'h2
`define SOS_OFS_AIN_UPPER 4'h3
`define SOS_OFS_AIN_LOWER 4'h4
`define SOS_OFS_TEMP_THR 4'h5
`define SOS_OFS_LOW_FREQ 4'h6
`define SOS_OFS_RUN_THR 4'h7
`define SOS_OFS_STATUS 4'h8
`define SOS_RST_SELECT 6'h00
`define SOS_RST_WORD 16'h0000
`define SOS_RST_UPPER 16'hFFFF
`endif

// ==== common/sos_pkg.sv ====
// Types shared by the status output selector files
package sos_pkg;
    typedef struct packed {
        logic [15:0] ain;
        logic [15:0] temp;
        logic [15:0] freq;
        logic [15:0] cur_run_time;
        logic [15:0] tot_run_time;
        logic stopped;
        logic reverse;
        logic fault;
        logic fault_continue;
    } sos_drive_s;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } sos_bus_s;
endpackage : sos_pkg

// ==== hdl/sos_cfg_reg.sv ====
// One configuration word register with reset value and address match
`timescale 1ns/1ps
`include "sos_map.svh"
module sos_cfg_reg #(
    parameter int W = 16,
    parameter logic [3:0] OFS = 4'h0,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire sos_pkg::sos_bus_s bus_in,
    output logic [W-1:0] value_out
);
    logic [W-1:0] value_reg;
    logic [W-1:0] value_next;

    always_comb begin
        value_next = value_reg;
        if (bus_in.wr && bus_in.addr == OFS) begin
            value_next = bus_in.wdata[W-1:0];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            value_reg <= RST;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value_out = value_reg;
endmodule : sos_cfg_reg

// ==== hdl/sos_cond_eval.sv ====
// Evaluates the one condition chosen by select_in from live drive quantities
`timescale 1ns/1ps
`include "sos_map.svh"
module sos_cond_eval (
    input wire sos_pkg::sos_drive_s drive_in,
    input wire logic timer_en_in,
    input wire logic [15:0] timer_dur_in,
    input wire logic [15:0] ain_upper_in,
    input wire logic [15:0] ain_lower_in,
    input wire logic [15:0] temp_thr_in,
    input wire logic [15:0] low_freq_in,
    input wire logic [15:0] run_thr_in,
    input wire logic [5:0] select_in,
    output logic cond_out
);
    always_comb begin
        unique case (select_in)
            `SOS_CODE_TIMER: cond_out = timer_en_in && drive_in.cur_run_time >= timer_dur_in; // [RL1]
            `SOS_CODE_AIN_WINDOW: cond_out = drive_in.ain > ain_upper_in || drive_in.ain < ain_lower_in; // [RL2]
            `SOS_CODE_STOPPED: cond_out = drive_in.stopped; // [RL3]
            `SOS_CODE_REVERSE: cond_out = drive_in.reverse && !drive_in.stopped; // [RL4]
            `SOS_CODE_HEATSINK: cond_out = drive_in.temp >= temp_thr_in; // [RL5]
            `SOS_CODE_LOW_FREQ: cond_out = drive_in.freq <= low_freq_in; // [RL6]
            `SOS_CODE_ALARM_CONT: cond_out = drive_in.fault && drive_in.fault_continue; // [RL7]
            `SOS_CODE_RUN_TIME: cond_out = drive_in.tot_run_time > run_thr_in; // [RL8]
            // Unsupported codes never assert the terminal
            default: cond_out = 1'b0; // [RL9]
        endcase
    end
endmodule : sos_cond_eval

// ==== hdl/sos_status_output_selector.sv ====
// Multifunction output terminal selector with register port
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "sos_map.svh"
// Contract
// RL1 - Code 30 with timer enabled: on once current run time reaches duration.
// RL2 - Code 31: on when analog input above upper or below lower limit.
// RL3 - Code 32: on while drive is stopped.
// RL4 - Code 33: on while drive runs in reverse.
// RL5 - Code 35: on when heatsink temperature reaches module threshold.
// RL6 - Code 37: on when running frequency reaches lower limit frequency.
// RL7 - Code 38: on when drive faulted and fault handling continues running.
// RL8 - Code 40: on once total running time exceeds threshold.
// RL9 - One code per terminal; output follows only that condition, else off.
module sos_status_output_selector (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic [15:0] analog_input_one_in,
    input wire logic [15:0] heatsink_temp_monitor_in,
    input wire logic [15:0] run_freq_in,
    input wire logic [15:0] cur_run_time_in,
    input wire logic [15:0] tot_run_time_in,
    input wire logic stopped_in,
    input wire logic reverse_in,
    input wire logic fault_in,
    input wire logic fault_continue_in,
    output logic terminal_out
);
    sos_pkg::sos_bus_s bus;
    sos_pkg::sos_drive_s drive;
    logic [15:0] select_word;
    logic [15:0] timer_ctrl;
    logic [15:0] timer_dur;
    logic [15:0] analog_upper_protect_limit;
    logic [15:0] analog_lower_protect_limit;
    logic [15:0] module_temp_threshold;
    logic [15:0] low_freq;
    logic [15:0] run_time_threshold;
    logic cond;
    logic terminal_reg;
    logic terminal_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;

    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
    assign drive = '{ain: analog_input_one_in, temp: heatsink_temp_monitor_in, freq: run_freq_in,
                     cur_run_time: cur_run_time_in, tot_run_time: tot_run_time_in,
                     stopped: stopped_in, reverse: reverse_in, fault: fault_in,
                     fault_continue: fault_continue_in};

    sos_cfg_reg #(.W(16), .OFS(`SOS_OFS_SELECT), .RST({10'h000, `SOS_RST_SELECT})) u_select (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .bus_in(bus),
        .value_out(select_word)
    );
    sos_cfg_reg #(.W(16), .OFS(`SOS_OFS_TIMER_CTRL), .RST(`SOS_RST_WORD)) u_timer_ctrl (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .bus_in(bus),
        .value_out(timer_ctrl)
    );
    sos_cfg_reg #(.W(16), .OFS(`SOS_OFS_TIMER_DUR), .RST(`SOS_RST_WORD)) u_timer_dur (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .bus_in(bus),
        .value_out(timer_dur)
    );
    // Upper limit resets high so the window does not fire before setup
    sos_cfg_reg #(.W(16), .OFS(`SOS_OFS_AIN_UPPER), .RST(`SOS_RST_UPPER)) u_ain_upper (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .bus_in(bus),
        .value_out(analog_upper_protect_limit)
    );
    sos_cfg_reg #(.W(16), .OFS(`SOS_OFS_AIN_LOWER), .RST(`SOS_RST_WORD)) u_ain_lower (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .bus_in(bus),
        .value_out(analog_lower_protect_limit)
    );
    sos_cfg_reg #(.W(16), .OFS(`SOS_OFS_TEMP_THR), .RST(`SOS_RST_UPPER)) u_temp_thr (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .bus_in(bus),
        .value_out(module_temp_threshold)
    );
    sos_cfg_reg #(.W(16), .OFS(`SOS_OFS_LOW_FREQ), .RST(`SOS_RST_WORD)) u_low_freq (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .bus_in(bus),
        .value_out(low_freq)
    );
    sos_cfg_reg #(.W(16), .OFS(`SOS_OFS_RUN_THR), .RST(`SOS_RST_UPPER)) u_run_thr (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .bus_in(bus),
        .value_out(run_time_threshold)
    );

    sos_cond_eval u_eval (
        .drive_in(drive),
        .timer_en_in(timer_ctrl[0]),
        .timer_dur_in(timer_dur),
        .ain_upper_in(analog_upper_protect_limit),
        .ain_lower_in(analog_lower_protect_limit),
        .temp_thr_in(module_temp_threshold),
        .low_freq_in(low_freq),
        .run_thr_in(run_time_threshold),
        .select_in(select_word[5:0]),
        .cond_out(cond)
    );

    // Registered so the pin never glitches while the code changes
    always_comb begin
        terminal_next = cond; // [RL9]
    end

    always_comb begin
        rdata_next = 16'h0000;
        if (rd_in) begin
            unique case (addr_in)
                `SOS_OFS_SELECT: rdata_next = select_word;
                `SOS_OFS_TIMER_CTRL: rdata_next = timer_ctrl;
                `SOS_OFS_TIMER_DUR: rdata_next = timer_dur;
                `SOS_OFS_AIN_UPPER: rdata_next = analog_upper_protect_limit;
                `SOS_OFS_AIN_LOWER: rdata_next = analog_lower_protect_limit;
                `SOS_OFS_TEMP_THR: rdata_next = module_temp_threshold;
                `SOS_OFS_LOW_FREQ: rdata_next = low_freq;
                `SOS_OFS_RUN_THR: rdata_next = run_time_threshold;
                `SOS_OFS_STATUS: rdata_next = {14'h0000, cond, terminal_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            terminal_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            terminal_reg <= terminal_next;
            rdata_reg <= rdata_next;
        end
    end

    assign terminal_out = terminal_reg;
    assign rdata_out = rdata_reg;

    property p_timer;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (select_word[5:0] == `SOS_CODE_TIMER) |=>
        (terminal_out == ($past(timer_ctrl[0]) && $past(cur_run_time_in) >= $past(timer_dur)));
    endproperty
    a_timer: assert property (p_timer) else $error("timer code mismatch"); // [RL1]

    property p_timer_off;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (select_word[5:0] == `SOS_CODE_TIMER && !timer_ctrl[0]) |=> !terminal_out;
    endproperty
    a_timer_off: assert property (p_timer_off) else $error("timer disabled but asserted"); // [RL1]

    property p_window;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (select_word[5:0] == `SOS_CODE_AIN_WINDOW) |=>
        (terminal_out == ($past(analog_input_one_in) > $past(analog_upper_protect_limit)
         || $past(analog_input_one_in) < $past(analog_lower_protect_limit)));
    endproperty
    a_window: assert property (p_window) else $error("analog window mismatch"); // [RL2]

    property p_stopped;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (select_word[5:0] == `SOS_CODE_STOPPED) |=> (terminal_out == $past(stopped_in));
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped code mismatch"); // [RL3]

    property p_reverse;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (select_word[5:0] == `SOS_CODE_REVERSE) |=> (terminal_out == ($past(reverse_in) && !$past(stopped_in)));
    endproperty
    a_reverse: assert property (p_reverse) else $error("reverse code mismatch"); // [RL4]

    property p_heatsink;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (select_word[5:0] == `SOS_CODE_HEATSINK) |=>
        (terminal_out == ($past(heatsink_temp_monitor_in) >= $past(module_temp_threshold)));
    endproperty
    a_heatsink: assert property (p_heatsink) else $error("heatsink code mismatch"); // [RL5]

    property p_low_freq;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (select_word[5:0] == `SOS_CODE_LOW_FREQ) |=> (terminal_out == ($past(run_freq_in) <= $past(low_freq)));
    endproperty
    a_low_freq: assert property (p_low_freq) else $error("lower frequency code mismatch"); // [RL6]

    property p_alarm;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (select_word[5:0] == `SOS_CODE_ALARM_CONT) |=> (terminal_out == ($past(fault_in) && $past(fault_continue_in)));
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm code mismatch"); // [RL7]

    property p_run_time;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (select_word[5:0] == `SOS_CODE_RUN_TIME) |=>
        (terminal_out == ($past(tot_run_time_in) > $past(run_time_threshold)));
    endproperty
    a_run_time: assert property (p_run_time) else $error("run time code mismatch"); // [RL8]

    property p_unsupported;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (select_word[5:0] == `SOS_RST_SELECT) [*2] |-> !terminal_out;
    endproperty
    a_unsupported: assert property (p_unsupported) else $error("unsupported code asserted"); // [RL9]

    property p_other_codes;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !(select_word[5:0] inside {`SOS_CODE_TIMER, `SOS_CODE_AIN_WINDOW, `SOS_CODE_STOPPED, `SOS_CODE_REVERSE,
          `SOS_CODE_HEATSINK, `SOS_CODE_LOW_FREQ, `SOS_CODE_ALARM_CONT, `SOS_CODE_RUN_TIME}) |=> !terminal_out;
    endproperty
    a_other_codes: assert property (p_other_codes) else $error("other code asserted terminal"); // [RL9]

    property p_rdata_idle;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !rd_in |=> (rdata_out == 16'h0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared"); // [RL9]

    property p_rd_select;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (rd_in && addr_in == `SOS_OFS_SELECT) |=> (rdata_out == $past(select_word));
    endproperty
    a_rd_select: assert property (p_rd_select) else $error("select readback mismatch"); // [RL9]

    property p_rd_status;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (rd_in && addr_in == `SOS_OFS_STATUS) |=> (rdata_out[15:2] == 14'h0000 && rdata_out[0] == $past(terminal_out));
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status readback mismatch"); // [RL9]

    property p_rd_unmapped;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (rd_in && addr_in > `SOS_OFS_STATUS) |=> (rdata_out == 16'h0000);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero"); // [RL9]

    property p_select_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_in && addr_in == `SOS_OFS_SELECT) |=> (select_word == $past(wdata_in));
    endproperty
    a_select_write: assert property (p_select_write) else $error("select write lost"); // [RL9]

    property p_select_hold;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !(wr_in && addr_in == `SOS_OFS_SELECT) |=> $stable(select_word);
    endproperty
    a_select_hold: assert property (p_select_hold) else $error("select changed without write"); // [RL9]

    property p_cfg_hold;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !wr_in |=> $stable({select_word, timer_ctrl, timer_dur, analog_upper_protect_limit,
                            analog_lower_protect_limit, module_temp_threshold, low_freq, run_time_threshold});
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("configuration changed without write"); // [RL9]

    property p_timer_ctrl_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_in && addr_in == `SOS_OFS_TIMER_CTRL) |=> (timer_ctrl == $past(wdata_in));
    endproperty
    a_timer_ctrl_write: assert property (p_timer_ctrl_write) else $error("timer control write lost"); // [RL1]

    property p_timer_dur_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_in && addr_in == `SOS_OFS_TIMER_DUR) |=> (timer_dur == $past(wdata_in));
    endproperty
    a_timer_dur_write: assert property (p_timer_dur_write) else $error("timer duration write lost"); // [RL1]

    property p_upper_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_in && addr_in == `SOS_OFS_AIN_UPPER) |=> (analog_upper_protect_limit == $past(wdata_in));
    endproperty
    a_upper_write: assert property (p_upper_write) else $error("upper limit write lost"); // [RL2]

    property p_lower_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_in && addr_in == `SOS_OFS_AIN_LOWER) |=> (analog_lower_protect_limit == $past(wdata_in));
    endproperty
    a_lower_write: assert property (p_lower_write) else $error("lower limit write lost"); // [RL2]

    property p_temp_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_in && addr_in == `SOS_OFS_TEMP_THR) |=> (module_temp_threshold == $past(wdata_in));
    endproperty
    a_temp_write: assert property (p_temp_write) else $error("temperature threshold write lost"); // [RL5]

    property p_low_freq_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_in && addr_in == `SOS_OFS_LOW_FREQ) |=> (low_freq == $past(wdata_in));
    endproperty
    a_low_freq_write: assert property (p_low_freq_write) else $error("lower frequency write lost"); // [RL6]

    property p_run_thr_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_in && addr_in == `SOS_OFS_RUN_THR) |=> (run_time_threshold == $past(wdata_in));
    endproperty
    a_run_thr_write: assert property (p_run_thr_write) else $error("run time threshold write lost"); // [RL8]
endmodule : sos_status_output_selector

// ==== verif/sos_terminal_reader.sv ====
// Far-side equipment model that latches the terminal level each clock
`timescale 1ns/1ps
module sos_terminal_reader (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic terminal_in,
    output logic seen_out
);
    logic seen_reg;
    logic seen_next;
    always_comb begin
        seen_next = terminal_in;
    end
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seen_reg <= 1'b0;
        end else begin
            seen_reg <= seen_next;
        end
    end
    assign seen_out = seen_reg;
endmodule : sos_terminal_reader

// ==== verif/sos_status_output_selector_test.sv ====
// Register and terminal tests for the status output selector
`timescale 1ns/1ps
`include "sos_map.svh"
module sos_status_output_selector_test;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [15:0] ain = 16'h0000;
    logic [15:0] temp = 16'h0000;
    logic [15:0] freq = 16'h0000;
    logic [15:0] cur = 16'h0000;
    logic [15:0] tot = 16'h0000;
    logic [3:0] flags = 4'h0;
    logic [15:0] rdata_out;
    logic terminal_out;
    logic seen;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    sos_status_output_selector i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .analog_input_one_in(ain), .heatsink_temp_monitor_in(temp), .run_freq_in(freq),
        .cur_run_time_in(cur), .tot_run_time_in(tot), .stopped_in(flags[3]), .reverse_in(flags[2]),
        .fault_in(flags[1]), .fault_continue_in(flags[0]), .terminal_out(terminal_out));
    sos_terminal_reader i_reader (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .terminal_in(terminal_out),
        .seen_out(seen));
    initial begin
        forever #10 mclk_in = ~mclk_in;
    end
    task automatic results();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            results();
        end
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        cmp(rdata_out, exp);
        // Read data stand for one cycle only
        @(posedge mclk_in);
        #1;
        cmp(rdata_out, 16'h0000);
    endtask : rd
    // Terminal plus what the far side latched, both settled
    task automatic term(input logic exp);
        repeat (3) @(posedge mclk_in);
        #1;
        cmp({15'h0000, terminal_out}, {15'h0000, exp});
        cmp({15'h0000, seen}, {15'h0000, exp});
    endtask : term
    initial begin
        repeat (10) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        rd(`SOS_OFS_SELECT, 16'h0000);
        rd(`SOS_OFS_TIMER_CTRL, 16'h0000);
        rd(`SOS_OFS_TIMER_DUR, 16'h0000);
        rd(`SOS_OFS_AIN_UPPER, 16'hFFFF);
        rd(`SOS_OFS_AIN_LOWER, 16'h0000);
        rd(`SOS_OFS_TEMP_THR, 16'hFFFF);
        rd(`SOS_OFS_LOW_FREQ, 16'h0000);
        rd(`SOS_OFS_RUN_THR, 16'hFFFF);
        wr(4'h9, 16'h1234);
        rd(4'h9, 16'h0000);
        wr(`SOS_OFS_SELECT, {10'h000, `SOS_CODE_STOPPED});
        rd(`SOS_OFS_SELECT, 16'h0020);
        flags <= 4'h8;
        term(1'b1);
        // Status is read-only: this write must leave it alone
        wr(`SOS_OFS_STATUS, 16'h0000);
        rd(`SOS_OFS_STATUS, 16'h0003);
        flags <= 4'h7;
        term(1'b0);
        wr(`SOS_OFS_SELECT, {10'h000, `SOS_CODE_REVERSE});
        flags <= 4'h4;
        term(1'b1);
        flags <= 4'h0;
        term(1'b0);
        wr(`SOS_OFS_SELECT, {10'h000, `SOS_CODE_TIMER});
        wr(`SOS_OFS_TIMER_DUR, 16'h0064);
        cur <= 16'h0064;
        term(1'b0);
        wr(`SOS_OFS_TIMER_CTRL, 16'h0001);
        term(1'b1);
        cur <= 16'h0063;
        term(1'b0);
        wr(`SOS_OFS_SELECT, {10'h000, `SOS_CODE_AIN_WINDOW});
        wr(`SOS_OFS_AIN_UPPER, 16'h0064);
        wr(`SOS_OFS_AIN_LOWER, 16'h000A);
        ain <= 16'h0065;
        term(1'b1);
        ain <= 16'h0064;
        term(1'b0);
        ain <= 16'h000A;
        term(1'b0);
        ain <= 16'h0009;
        term(1'b1);
        wr(`SOS_OFS_SELECT, {10'h000, `SOS_CODE_HEATSINK});
        wr(`SOS_OFS_TEMP_THR, 16'h0050);
        temp <= 16'h004F;
        term(1'b0);
        temp <= 16'h0050;
        term(1'b1);
        wr(`SOS_OFS_SELECT, {10'h000, `SOS_CODE_LOW_FREQ});
        wr(`SOS_OFS_LOW_FREQ, 16'h01F4);
        freq <= 16'h01F5;
        term(1'b0);
        freq <= 16'h01F4;
        term(1'b1);
        wr(`SOS_OFS_SELECT, {10'h000, `SOS_CODE_ALARM_CONT});
        flags <= 4'h2;
        term(1'b0);
        flags <= 4'h3;
        term(1'b1);
        flags <= 4'h1;
        term(1'b0);
        wr(`SOS_OFS_SELECT, {10'h000, `SOS_CODE_RUN_TIME});
        wr(`SOS_OFS_RUN_THR, 16'h03E8);
        tot <= 16'h03E8;
        term(1'b0);
        tot <= 16'h03E9;
        term(1'b1);
        // Many conditions true: only the selected one may matter
        cur <= 16'h0064;
        flags <= 4'hB;
        wr(`SOS_OFS_SELECT, 16'h0022);
        term(1'b0);
        wr(`SOS_OFS_SELECT, 16'h003F);
        term(1'b0);
        flags <= 4'h7;
        wr(`SOS_OFS_SELECT, {10'h000, `SOS_CODE_STOPPED});
        term(1'b0);
        // Upper select bits are stored but must not change the decode
        flags <= 4'h8;
        wr(`SOS_OFS_SELECT, 16'hFFE0);
        term(1'b1);
        rd(`SOS_OFS_SELECT, 16'hFFE0);
        // Mid-run reset drops the terminal and restores the defaults
        rst_n_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        term(1'b0);
        rd(`SOS_OFS_SELECT, 16'h0000);
        rd(`SOS_OFS_AIN_UPPER, 16'hFFFF);
        results();
    end
endmodule : sos_status_output_selector_test
